// File: rtl/gasr_pkg.sv
package gasr_pkg;
  // register indices
  localparam logic [7:0] ADDR_POWER_MODE = 8'h15;
  localparam logic [7:0] ADDR_THERM_CTRL = 8'h16;
  localparam logic [7:0] ADDR_PACK_STATE = 8'h19;
  localparam logic [7:0] ADDR_EOC_RATE = 8'h1c;
  localparam logic [7:0] ADDR_EMPTY_V = 8'h1d;
  localparam logic [7:0] ADDR_EMPTY_OFS = 8'h1e;
  localparam logic [7:0] ADDR_HI_V = 8'h1f;
  localparam logic [7:0] ADDR_LO_T = 8'h20;
  localparam logic [7:0] ADDR_HI_T = 8'h21;
  localparam logic [7:0] ADDR_OVC = 8'h22;
  localparam logic [7:0] ADDR_OVD = 8'h23;
  localparam logic [7:0] ADDR_RUN_LO = 8'h24;
  localparam logic [7:0] ADDR_RUN_HI = 8'h25;
  localparam logic [7:0] ADDR_TACC_LO = 8'h26;
  localparam logic [7:0] ADDR_TACC_HI = 8'h27;
  localparam logic [7:0] ADDR_CACC_LO = 8'h28;
  localparam logic [7:0] ADDR_CACC_HI = 8'h29;
  localparam logic [7:0] ADDR_PK_V = 8'h2a;
  localparam logic [7:0] ADDR_LO_V = 8'h2b;
  localparam logic [7:0] ADDR_PK_T = 8'h2c;
  localparam logic [7:0] ADDR_LOW_T = 8'h2d;
  localparam logic [7:0] ADDR_PK_IC = 8'h2e;
  localparam logic [7:0] ADDR_PK_ID = 8'h2f;
  localparam logic [7:0] ADDR_AMB_T = 8'h30;
  localparam logic [7:0] ADDR_SHUNT = 8'h31;
  localparam logic [7:0] ADDR_HEALTH = 8'h32;
  localparam logic [7:0] ADDR_INST_I = 8'h33;
  localparam logic [7:0] ADDR_MEAN_I = 8'h34;
  localparam logic [7:0] ADDR_CAP_LEFT = 8'h35;
  localparam logic [7:0] ADDR_USER_LO = 8'h36;
  localparam logic [7:0] ADDR_USER_HI = 8'h37;
  // pack state bits
  localparam int BIT_HI_V = 15;
  localparam int BIT_OVC = 13;
  localparam int BIT_HI_T = 12;
  localparam int BIT_OVD = 10;
  localparam int BIT_LO_T = 8;
  localparam int BIT_INIT = 7;
  localparam int BIT_DISCH = 6;
  localparam logic [15:0] ALARM_MASK = 16'hb500;
  localparam logic [15:0] PACK_STATE_RST = 16'h00c0;
  // power modes
  localparam logic [15:0] MODE_OPER = 16'h0001;
  localparam logic [15:0] MODE_SLEEP = 16'h0002;
  localparam logic [15:0] MODE_RST = MODE_SLEEP;
  // gauging constants
  localparam logic [15:0] TEMP_ZERO_C = 16'h0aac;
  localparam logic [15:0] LEVEL_FULL = 16'h03e8;
  localparam logic [15:0] EOC_RATE_RST = 16'h0002;
  localparam logic [15:0] HEALTH_RST = 16'h0064;
  localparam logic [15:0] SHUNT_RST = 16'h0064;
  localparam logic [23:0] RUN_MAX = 24'hffffff;
  localparam logic [31:0] CACC_MAX = 32'h0fffffff;
  localparam logic [15:0] AMB_MIN = 16'h0980;
  localparam logic [15:0] AMB_MAX = 16'h0dcc;
  // one minute at 250 MHz
  localparam longint MINUTE_NS = 60000000000;
  localparam longint CLK_NS = 4;
  localparam longint MINUTE_CYC = MINUTE_NS / CLK_NS;
  localparam logic [31:0] USER_WORD_VAL = 32'h5a5a0001; // arbitrary
endpackage : gasr_pkg

// File: rtl/gasr_regs.sv
`timescale 1ns/10ps
// Summary of operation
// R01 - end rate sets full point, 0.01C units
// R02 - level full 0x3e8 at 0.02C charge
// R03 - rate above 0x02 subtracts full offset
// R04 - capture empty offset under three conditions
// R05 - zero empty voltage disables capture
// R06 - relative charge zero at empty offset
// R07 - alarm flags sticky until host write
// R08 - high voltage alarm, bit 15
// R09 - low temperature alarm, bit 8
// R10 - high temperature alarm, bit 12
// R11 - overcharge current alarm, bit 13
// R12 - overdischarge current alarm, bit 10
// R13 - runtime minutes, saturate, writable
// R14 - charge accumulator per minute, saturate
// R15 - peak voltage tracker
// R16 - lowest voltage tracker
// R17 - temperature min/max trackers
// R18 - current min/max trackers
// R19 - ambient temperature loaded when enabled
// R20 - host programs shunt value
// R21 - signed instant and mean shunt voltage
// R22 - health starts 100, only decreases
// R23 - power mode 01 operate, 02 sleep
// R24 - sleep releases alarm output
// R25 - thermistor enable bits 0 and 1
// R26 - any active alarm drives output low
module gasr_regs #(
  parameter longint MINUTE_CYCLES = gasr_pkg::MINUTE_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_hit,
  input wire logic meas_valid,
  input wire logic [15:0] cell_voltage,
  input wire logic [15:0] cell_temp,
  input wire logic [15:0] ambient_meas,
  input wire logic [15:0] shunt_meas,
  input wire logic [15:0] shunt_mean,
  input wire logic [15:0] indicated_level,
  input wire logic [15:0] full_offset,
  input wire logic [15:0] capacity_meas,
  input wire logic health_dec,
  input wire logic discharging,
  output logic [15:0] relative_charge,
  output logic [15:0] shunt_value,
  output logic [15:0] end_of_charge_rate,
  output logic [1:0] thermistor_en,
  output logic alarm_out_n
);
  typedef enum logic [1:0] {
    GASR_OPER = 2'b01,
    GASR_SLEEP = 2'b10
  } gasr_mode_e;

  gasr_mode_e mode;
  logic [15:0] empty_voltage_level, empty_level_offset;
  logic [15:0] high_voltage_threshold, low_temp_threshold;
  logic [15:0] high_temp_threshold, overcharge_threshold;
  logic [15:0] overdischarge_threshold, pack_state_word;
  logic [23:0] operating_minutes;
  logic [31:0] temperature_accumulator, charge_level_accumulator;
  logic [15:0] peak_voltage, lowest_voltage;
  logic [15:0] peak_temperature, lowest_temperature;
  logic [15:0] peak_charge_current, peak_discharge_current;
  logic [15:0] ambient_temp, health_percent;
  logic [15:0] instant_shunt_voltage, mean_shunt_voltage;
  logic [15:0] capacity_left;
  logic [15:0] hold_rd;
  logic [39:0] minute_cnt;
  logic minute_tick, oper, alarm_any;
  logic cond_hv, cond_lt, cond_ht, cond_oc, cond_od;
  logic [15:0] alarm_set;

  function automatic logic wr_to(input logic [7:0] a);
    wr_to = reg_wr && (reg_addr == a);
  endfunction : wr_to

  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction : sgt

  assign oper = (mode == GASR_OPER);

  // minute divider, frozen in sleep
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      minute_cnt <= 40'h0;
    end else if (!oper) begin
      minute_cnt <= minute_cnt;
    end else if (minute_cnt >= 40'(MINUTE_CYCLES - 1)) begin
      minute_cnt <= 40'h0;
    end else begin
      minute_cnt <= minute_cnt + 40'h1;
    end
  end
  assign minute_tick = oper && (minute_cnt >= 40'(MINUTE_CYCLES - 1));

  // mode and thermistor bits
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode <= GASR_SLEEP;
      thermistor_en <= 2'b00;
    end else begin
      if (wr_to(gasr_pkg::ADDR_POWER_MODE)) begin
        if (reg_wdata == gasr_pkg::MODE_OPER) mode <= GASR_OPER; // R23
        else if (reg_wdata == gasr_pkg::MODE_SLEEP) mode <= GASR_SLEEP;
      end
      if (wr_to(gasr_pkg::ADDR_THERM_CTRL)) begin
        thermistor_en <= reg_wdata[1:0]; // R25
      end
    end
  end

  // settings
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      end_of_charge_rate <= gasr_pkg::EOC_RATE_RST;
      empty_voltage_level <= 16'h0;
      high_voltage_threshold <= 16'h0;
      low_temp_threshold <= 16'h0;
      high_temp_threshold <= 16'h0;
      overcharge_threshold <= 16'h0;
      overdischarge_threshold <= 16'h0;
      shunt_value <= gasr_pkg::SHUNT_RST;
    end else begin
      if (wr_to(gasr_pkg::ADDR_EOC_RATE)) end_of_charge_rate <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_EMPTY_V)) empty_voltage_level <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_HI_V)) high_voltage_threshold <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_LO_T)) low_temp_threshold <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_HI_T)) high_temp_threshold <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_OVC)) overcharge_threshold <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_OVD)) overdischarge_threshold <= reg_wdata;
      if (wr_to(gasr_pkg::ADDR_SHUNT)) shunt_value <= reg_wdata; // R20
    end
  end

  // empty offset; write beats capture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      empty_level_offset <= 16'h0;
    end else if (wr_to(gasr_pkg::ADDR_EMPTY_OFS)) begin
      empty_level_offset <= reg_wdata;
    end else if (oper && meas_valid && empty_voltage_level != 16'h0 // R05
                 && cell_voltage < empty_voltage_level
                 && indicated_level > empty_level_offset
                 && cell_temp > gasr_pkg::TEMP_ZERO_C) begin
      empty_level_offset <= indicated_level; // R04
    end
  end

  // rescale level to percent between empty and full
  always_comb begin
    logic [15:0] top;
    logic [15:0] span;
    logic [31:0] num;
    top = gasr_pkg::LEVEL_FULL;
    // rate above 0x02 lowers the full point
    if (end_of_charge_rate > gasr_pkg::EOC_RATE_RST) begin // R01 R03
      top = gasr_pkg::LEVEL_FULL - full_offset;
    end
    span = top - empty_level_offset;
    num = 32'h0;
    if (indicated_level <= empty_level_offset || span == 16'h0 ||
        top <= empty_level_offset) begin
      relative_charge = 16'h0; // R06
    end else if (indicated_level >= top) begin
      relative_charge = 16'h0064; // R02
    end else begin
      num = 32'(indicated_level - empty_level_offset) * 32'h64;
      relative_charge = 16'(num / {16'h0, span});
    end
  end

  // live alarms, zero threshold disables
  assign cond_hv = oper && high_voltage_threshold != 16'h0 &&
                   cell_voltage > high_voltage_threshold; // R08
  assign cond_lt = oper && thermistor_en[0] && low_temp_threshold != 16'h0
                   && cell_temp < low_temp_threshold; // R09
  assign cond_ht = oper && thermistor_en[0] && high_temp_threshold != 16'h0
                   && cell_temp > high_temp_threshold; // R10
  assign cond_oc = oper && overcharge_threshold != 16'h0 &&
                   sgt(instant_shunt_voltage, overcharge_threshold); // R11
  assign cond_od = oper && overdischarge_threshold != 16'h0 &&
                   sgt(overdischarge_threshold, instant_shunt_voltage); // R12

  always_comb begin
    alarm_set = 16'h0;
    alarm_set[gasr_pkg::BIT_HI_V] = cond_hv;
    alarm_set[gasr_pkg::BIT_LO_T] = cond_lt;
    alarm_set[gasr_pkg::BIT_HI_T] = cond_ht;
    alarm_set[gasr_pkg::BIT_OVC] = cond_oc;
    alarm_set[gasr_pkg::BIT_OVD] = cond_od;
  end

  // sticky flags; live set beats a clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pack_state_word <= gasr_pkg::PACK_STATE_RST;
    end else begin
      if (wr_to(gasr_pkg::ADDR_PACK_STATE)) begin
        pack_state_word <= (reg_wdata & gasr_pkg::ALARM_MASK) | alarm_set; // R07
        pack_state_word[gasr_pkg::BIT_INIT] <= reg_wdata[gasr_pkg::BIT_INIT];
      end else begin
        pack_state_word <= pack_state_word | alarm_set; // R07
      end
      pack_state_word[gasr_pkg::BIT_DISCH] <= discharging;
    end
  end

  // live conditions; sleep forces release
  assign alarm_any = cond_hv | cond_lt | cond_ht | cond_oc | cond_od; // R26
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) alarm_out_n <= 1'b1;
    else alarm_out_n <= ~(alarm_any & oper); // R24
  end

  // accumulators; a write loads one half and beats the minute tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      operating_minutes <= 24'h0;
      charge_level_accumulator <= 32'h0;
      temperature_accumulator <= 32'h0;
    end else begin
      if (wr_to(gasr_pkg::ADDR_RUN_LO)) begin
        operating_minutes[15:0] <= reg_wdata; // R13
      end else if (wr_to(gasr_pkg::ADDR_RUN_HI)) begin
        operating_minutes[23:16] <= reg_wdata[7:0];
      end else if (minute_tick && operating_minutes != gasr_pkg::RUN_MAX) begin
        operating_minutes <= operating_minutes + 24'h1; // R13
      end
      if (wr_to(gasr_pkg::ADDR_CACC_LO)) begin
        charge_level_accumulator[15:0] <= reg_wdata; // R14
      end else if (wr_to(gasr_pkg::ADDR_CACC_HI)) begin
        charge_level_accumulator[31:16] <= reg_wdata;
      end else if (minute_tick) begin
        // saturate rather than wrap
        if (charge_level_accumulator + {16'h0, relative_charge} >=
            gasr_pkg::CACC_MAX) begin
          charge_level_accumulator <= gasr_pkg::CACC_MAX; // R14
        end else begin
          charge_level_accumulator <= charge_level_accumulator +
                                      {16'h0, relative_charge};
        end
      end
      if (wr_to(gasr_pkg::ADDR_TACC_LO)) begin
        temperature_accumulator[15:0] <= reg_wdata;
      end else if (wr_to(gasr_pkg::ADDR_TACC_HI)) begin
        temperature_accumulator[31:16] <= reg_wdata;
      end
    end
  end

  // trackers; a write sets the baseline
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peak_voltage <= 16'h0;
      lowest_voltage <= 16'hffff;
      peak_temperature <= 16'h0;
      lowest_temperature <= 16'hffff;
      peak_charge_current <= 16'h8000;
      peak_discharge_current <= 16'h7fff;
    end else begin
      if (wr_to(gasr_pkg::ADDR_PK_V)) peak_voltage <= reg_wdata;
      else if (meas_valid && cell_voltage > peak_voltage)
        peak_voltage <= cell_voltage; // R15
      if (wr_to(gasr_pkg::ADDR_LO_V)) lowest_voltage <= reg_wdata;
      else if (meas_valid && cell_voltage < lowest_voltage)
        lowest_voltage <= cell_voltage; // R16
      if (wr_to(gasr_pkg::ADDR_PK_T)) peak_temperature <= reg_wdata;
      else if (meas_valid && thermistor_en[0] && cell_temp > peak_temperature)
        peak_temperature <= cell_temp; // R17
      if (wr_to(gasr_pkg::ADDR_LOW_T)) lowest_temperature <= reg_wdata;
      else if (meas_valid && thermistor_en[0] &&
               cell_temp < lowest_temperature)
        lowest_temperature <= cell_temp; // R17
      if (wr_to(gasr_pkg::ADDR_PK_IC)) peak_charge_current <= reg_wdata;
      else if (meas_valid && sgt(shunt_meas, peak_charge_current))
        peak_charge_current <= shunt_meas; // R18
      if (wr_to(gasr_pkg::ADDR_PK_ID)) peak_discharge_current <= reg_wdata;
      else if (meas_valid && sgt(peak_discharge_current, shunt_meas))
        peak_discharge_current <= shunt_meas; // R18
    end
  end

  // measured values; ambient is clamped to its span
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ambient_temp <= 16'h0;
      instant_shunt_voltage <= 16'h0;
      mean_shunt_voltage <= 16'h0;
      capacity_left <= 16'h0;
      health_percent <= gasr_pkg::HEALTH_RST;
    end else if (meas_valid) begin
      if (thermistor_en[1]) begin // R19
        if (ambient_meas < gasr_pkg::AMB_MIN) ambient_temp <= gasr_pkg::AMB_MIN;
        else if (ambient_meas > gasr_pkg::AMB_MAX)
          ambient_temp <= gasr_pkg::AMB_MAX;
        else ambient_temp <= ambient_meas;
      end
      instant_shunt_voltage <= shunt_meas; // R21
      mean_shunt_voltage <= shunt_mean; // R21
      capacity_left <= capacity_meas;
      // never below zero, never rising
      if (health_dec && health_percent != 16'h0)
        health_percent <= health_percent - 16'h1; // R22
    end
  end

  // read mux; unmapped reads zero
  always_comb begin
    reg_hit = 1'b1;
    case (reg_addr)
      gasr_pkg::ADDR_POWER_MODE: hold_rd = oper ? gasr_pkg::MODE_OPER
                                                : gasr_pkg::MODE_SLEEP;
      gasr_pkg::ADDR_THERM_CTRL: hold_rd = {14'h0, thermistor_en};
      gasr_pkg::ADDR_PACK_STATE: hold_rd = pack_state_word;
      gasr_pkg::ADDR_EOC_RATE: hold_rd = end_of_charge_rate;
      gasr_pkg::ADDR_EMPTY_V: hold_rd = empty_voltage_level;
      gasr_pkg::ADDR_EMPTY_OFS: hold_rd = empty_level_offset;
      gasr_pkg::ADDR_HI_V: hold_rd = high_voltage_threshold;
      gasr_pkg::ADDR_LO_T: hold_rd = low_temp_threshold;
      gasr_pkg::ADDR_HI_T: hold_rd = high_temp_threshold;
      gasr_pkg::ADDR_OVC: hold_rd = overcharge_threshold;
      gasr_pkg::ADDR_OVD: hold_rd = overdischarge_threshold;
      gasr_pkg::ADDR_RUN_LO: hold_rd = operating_minutes[15:0];
      gasr_pkg::ADDR_RUN_HI: hold_rd = {8'h0, operating_minutes[23:16]};
      gasr_pkg::ADDR_TACC_LO: hold_rd = temperature_accumulator[15:0];
      gasr_pkg::ADDR_TACC_HI: hold_rd = temperature_accumulator[31:16];
      gasr_pkg::ADDR_CACC_LO: hold_rd = charge_level_accumulator[15:0];
      gasr_pkg::ADDR_CACC_HI: hold_rd = charge_level_accumulator[31:16];
      gasr_pkg::ADDR_PK_V: hold_rd = peak_voltage;
      gasr_pkg::ADDR_LO_V: hold_rd = lowest_voltage;
      gasr_pkg::ADDR_PK_T: hold_rd = peak_temperature;
      gasr_pkg::ADDR_LOW_T: hold_rd = lowest_temperature;
      gasr_pkg::ADDR_PK_IC: hold_rd = peak_charge_current;
      gasr_pkg::ADDR_PK_ID: hold_rd = peak_discharge_current;
      gasr_pkg::ADDR_AMB_T: hold_rd = ambient_temp;
      gasr_pkg::ADDR_SHUNT: hold_rd = shunt_value;
      gasr_pkg::ADDR_HEALTH: hold_rd = health_percent;
      gasr_pkg::ADDR_INST_I: hold_rd = instant_shunt_voltage;
      gasr_pkg::ADDR_MEAN_I: hold_rd = mean_shunt_voltage;
      gasr_pkg::ADDR_CAP_LEFT: hold_rd = capacity_left;
      gasr_pkg::ADDR_USER_LO: hold_rd = gasr_pkg::USER_WORD_VAL[15:0];
      gasr_pkg::ADDR_USER_HI: hold_rd = gasr_pkg::USER_WORD_VAL[31:16];
      default: begin
        hold_rd = 16'h0;
        reg_hit = 1'b0;
      end
    endcase
  end

  // read data held until next strobe
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 16'h0;
    else if (reg_rd) reg_rdata <= hold_rd;
  end
endmodule : gasr_regs

// File: tb/gasr_regs_chk.sv
`timescale 1ns/10ps
module gasr_regs_chk #(
  parameter longint MINUTE_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_hit,
  input wire logic meas_valid,
  input wire logic [15:0] cell_voltage,
  input wire logic [15:0] shunt_meas,
  input wire logic [15:0] relative_charge,
  input wire logic [15:0] shunt_value,
  input wire logic [15:0] end_of_charge_rate,
  input wire logic [1:0] thermistor_en,
  input wire logic alarm_out_n
);
  logic oper;
  logic [15:0] hv_thr, ovc_thr, ovd_thr;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // shadows, updated on the design's edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oper <= 1'b0;
      hv_thr <= 16'h0000;
      ovc_thr <= 16'h0000;
      ovd_thr <= 16'h0000;
    end else if (reg_wr) begin
      if (reg_addr == gasr_pkg::ADDR_POWER_MODE) begin
        // other codes ignored
        if (reg_wdata == gasr_pkg::MODE_OPER) oper <= 1'b1;
        else if (reg_wdata == gasr_pkg::MODE_SLEEP) oper <= 1'b0;
      end
      if (reg_addr == gasr_pkg::ADDR_HI_V) hv_thr <= reg_wdata;
      if (reg_addr == gasr_pkg::ADDR_OVC) ovc_thr <= reg_wdata;
      if (reg_addr == gasr_pkg::ADDR_OVD) ovd_thr <= reg_wdata;
    end
  end
  AST_RATE_WR: assert property (
    reg_wr && reg_addr == gasr_pkg::ADDR_EOC_RATE
    |=> end_of_charge_rate == $past(reg_wdata)) else $error("rate write lost");
  AST_THERM_WR: assert property (
    reg_wr && reg_addr == gasr_pkg::ADDR_THERM_CTRL |=>
    {14'h0000, thermistor_en} == ($past(reg_wdata) & 16'h0003))
    else $error("therm write lost");
  AST_SHUNT_WR: assert property (
    reg_wr && reg_addr == gasr_pkg::ADDR_SHUNT
    |=> shunt_value == $past(reg_wdata)) else $error("shunt write lost");
  AST_SLEEP_REL: assert property (
    !oper |=> alarm_out_n) else $error("alarm driven in sleep");
  AST_HV_ALARM: assert property (
    oper && hv_thr != 16'h0000 && cell_voltage > hv_thr |=> !alarm_out_n)
    else $error("hv alarm missing");
  AST_OVC_ALARM: assert property (
    meas_valid && oper && ovc_thr != 16'h0000 &&
    $signed(shunt_meas) > $signed(ovc_thr) |-> ##2 !alarm_out_n)
    else $error("ovc alarm missing");
  AST_OVD_ALARM: assert property (
    meas_valid && oper && ovd_thr != 16'h0000 &&
    $signed(shunt_meas) < $signed(ovd_thr) |-> ##2 !alarm_out_n)
    else $error("ovd alarm missing");
  AST_RC_RANGE: assert property (
    relative_charge <= 16'h0064) else $error("charge above full");
  cover property (!alarm_out_n);
  cover property (reg_rd && !reg_hit);
  cover property (reg_wr && reg_addr == gasr_pkg::ADDR_POWER_MODE
    && reg_wdata == gasr_pkg::MODE_SLEEP);
endmodule : gasr_regs_chk
bind gasr_regs gasr_regs_chk #(.MINUTE_CYCLES(MINUTE_CYCLES)) gasr_regs_chk_inst (
  .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_hit(reg_hit),
  .cell_voltage(cell_voltage), .shunt_meas(shunt_meas),
  .relative_charge(relative_charge), .shunt_value(shunt_value),
  .end_of_charge_rate(end_of_charge_rate), .thermistor_en(thermistor_en),
  .alarm_out_n(alarm_out_n), .meas_valid(meas_valid));

// File: tb/gasr_host.sv
`timescale 1ns/10ps
// register host; idle lines show the inverse
module gasr_host (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  // data registers at the sampling edge
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : gasr_host

// File: tb/gasr_regs_tb.sv
`timescale 1ns/10ps
module gasr_regs_tb;
  logic clock = 1'b0, rst_n = 1'b0, meas_valid = 1'b0, health_dec = 1'b0;
  logic discharging = 1'b1, reg_wr, reg_rd, reg_hit, alarm_out_n;
  logic [7:0] reg_addr;
  logic [1:0] thermistor_en;
  logic [15:0] reg_wdata, reg_rdata, relative_charge, shunt_value, eoc;
  logic [15:0] cell_voltage = 16'h0e00, cell_temp = 16'h0b80;
  logic [15:0] ambient_meas = 16'h0b00, shunt_meas = 16'h0000;
  logic [15:0] shunt_mean = 16'h0010, indicated_level = 16'h01f4;
  logic [15:0] full_offset = 16'h0000, capacity_meas = 16'h0100;
  int failures = 0;
  int total_checks = 0;
  gasr_regs #(.MINUTE_CYCLES(10)) gasr_regs_inst (.clock(clock),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .meas_valid(meas_valid), .cell_voltage(cell_voltage),
    .cell_temp(cell_temp), .ambient_meas(ambient_meas),
    .shunt_meas(shunt_meas), .shunt_mean(shunt_mean),
    .indicated_level(indicated_level), .full_offset(full_offset),
    .capacity_meas(capacity_meas), .health_dec(health_dec),
    .discharging(discharging), .relative_charge(relative_charge),
    .shunt_value(shunt_value), .end_of_charge_rate(eoc),
    .thermistor_en(thermistor_en), .alarm_out_n(alarm_out_n));
  gasr_host gasr_host_inst (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  always #2 clock = ~clock;
  task automatic chk(input logic [15:0] got, exp, input string m);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    gasr_host_inst.wr(a, v);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    gasr_host_inst.rd(a, v);
    chk(v, exp, $sformatf("read %h", a));
  endtask : rchk
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : w
  // one-cycle measurement strobe
  task automatic pulse();
    w(1);
    meas_valid = 1'b1;
    w(1);
    meas_valid = 1'b0;
  endtask : pulse
  task automatic st(input logic [1:0] k, input logic [15:0] v);
    case (k)
      2'd0: cell_voltage = v;
      2'd1: cell_temp = v;
      default: begin
        shunt_meas = v;
        pulse();
      end
    endcase
  endtask : st
  function automatic logic [15:0] nom(input logic [1:0] k);
    return (k == 2'd0) ? 16'h0e00 : (k == 2'd1) ? 16'h0b80 : 16'h0000;
  endfunction : nom
  task automatic t_misc();
    rchk(8'h19, 16'h00c0);
    chk(eoc, 16'h0002, "rate reset");
    rchk(8'h32, 16'h0064);
    rchk(8'h40, 16'h0000);
    st(2'd2, 16'hff38);
    rchk(8'h33, 16'hff38);
    rchk(8'h34, 16'h0010);
    st(2'd2, 16'h0000);
    health_dec = 1'b1;
    pulse();
    health_dec = 1'b0;
    rchk(8'h32, 16'h0063);
    wr(8'h31, 16'h0014);
    chk(shunt_value, 16'h0014, "shunt value");
    wr(8'h16, 16'h0003);
    pulse();
    rchk(8'h30, 16'h0b00);
    ambient_meas = 16'h0f00;
    pulse();
    rchk(8'h30, 16'h0dcc);
    $display("test misc done");
  endtask : t_misc
  task automatic t_alarms();
    logic [7:0] a[5] = '{8'h1f, 8'h20, 8'h21, 8'h22, 8'h23};
    logic [15:0] th[5] = '{16'h1000, 16'h0b00, 16'h0c00, 16'h0100, 16'hff00};
    logic [15:0] sv[5] = '{16'h1100, 16'h0a00, 16'h0d00, 16'h0200, 16'hfe00};
    logic [1:0] k[5] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2};
    int b[5] = '{15, 8, 12, 13, 10};
    wr(8'h15, 16'h0001);
    wr(8'h16, 16'h0001);
    chk(16'(thermistor_en), 16'h0001, "therm en");
    for (int i = 0; i < 5; i++) begin
      wr(a[i], th[i]);
      st(k[i], sv[i]);
      w(3);
      chk(16'(alarm_out_n), 16'h0000, "alarm low");
      rchk(8'h19, 16'h00c0 | (16'h0001 << b[i]));
      st(k[i], nom(k[i]));
      w(3);
      chk(16'(alarm_out_n), 16'h0001, "alarm released");
      rchk(8'h19, 16'h00c0 | (16'h0001 << b[i]));
      wr(8'h19, 16'h0080);
      rchk(8'h19, 16'h00c0);
      wr(a[i], 16'h0000);
    end
    $display("test alarms done");
  endtask : t_alarms
  task automatic t_sleep();
    wr(8'h1f, 16'h1000);
    st(2'd0, 16'h1100);
    w(3);
    chk(16'(alarm_out_n), 16'h0000, "alarm before sleep");
    wr(8'h15, 16'h0002);
    w(2);
    chk(16'(alarm_out_n), 16'h0001, "sleep release");
    wr(8'h15, 16'h0003);
    rchk(8'h15, 16'h0002);
    wr(8'h15, 16'h0001);
    w(3);
    chk(16'(alarm_out_n), 16'h0000, "wake alarm");
    st(2'd0, 16'h0e00);
    wr(8'h1f, 16'h0000);
    wr(8'h19, 16'h0080);
    $display("test sleep done");
  endtask : t_sleep
  task automatic trk(input logic [7:0] a, input logic [1:0] k,
                     input logic [15:0] w0, ext, mild);
    wr(a, w0);
    st(k, ext);
    pulse();
    rchk(a, ext);
    st(k, mild);
    pulse();
    rchk(a, ext);
    st(k, nom(k));
  endtask : trk
  task automatic t_minutes();
    wr(8'h25, 16'h00ff);
    wr(8'h24, 16'hfffd);
    wr(8'h29, 16'h0fff);
    wr(8'h28, 16'hff00);
    w(100);
    rchk(8'h24, 16'hffff);
    rchk(8'h25, 16'h00ff);
    rchk(8'h28, 16'hffff);
    rchk(8'h29, 16'h0fff);
    wr(8'h15, 16'h0002);
    wr(8'h24, 16'h0005);
    wr(8'h25, 16'h0000);
    wr(8'h28, 16'h0007);
    wr(8'h29, 16'h0000);
    w(40);
    rchk(8'h24, 16'h0005);
    rchk(8'h28, 16'h0007);
    $display("test minutes done");
  endtask : t_minutes
  task automatic t_empty();
    chk(relative_charge, 16'h0032, "half level");
    wr(8'h1e, 16'h01f4);
    chk(relative_charge, 16'h0000, "at offset");
    wr(8'h1e, 16'h0000);
    wr(8'h15, 16'h0001);
    wr(8'h1d, 16'h0c00);
    st(2'd0, 16'h0b00);
    pulse();
    rchk(8'h1e, 16'h01f4);
    wr(8'h1d, 16'h0000);
    wr(8'h1e, 16'h0000);
    pulse();
    rchk(8'h1e, 16'h0000);
    st(2'd0, 16'h0e00);
    indicated_level = 16'h03e8;
    #1 chk(relative_charge, 16'h0064, "full at rate 2");
    wr(8'h1c, 16'h000a);
    full_offset = 16'h0064;
    indicated_level = 16'h0384;
    #1 chk(relative_charge, 16'h0064, "early full");
    $display("test empty done");
  endtask : t_empty
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_misc();
    t_alarms();
    t_sleep();
    trk(8'h2a, 2'd0, 16'h0100, 16'h0300, 16'h0200);
    trk(8'h2b, 2'd0, 16'h0f00, 16'h0100, 16'h0200);
    trk(8'h2c, 2'd1, 16'h0900, 16'h0c00, 16'h0b00);
    trk(8'h2d, 2'd1, 16'h0c00, 16'h0a00, 16'h0b00);
    trk(8'h2e, 2'd2, 16'h0000, 16'h0300, 16'h0100);
    trk(8'h2f, 2'd2, 16'h0000, 16'hfd00, 16'hff00);
    t_minutes();
    t_empty();
    end_sim();
  end
  // hang guard, about 23x run length
  initial begin
    #40000;
    failures++;
    end_sim();
  end
endmodule : gasr_regs_tb
